// [include/atbs_pkg.sv]
// Contract
// RQ1 - arm configured: triggers ignored until armed
// RQ2 - no arm: search trigger from start
// RQ3 - disarm match returns to arm search
// RQ4 - disarm only allowed with arm configured
// RQ5 - delay and disarm together are rejected
// RQ6 - instruction delay counts instructions after trigger
// RQ7 - match_count_delay delay counts trigger matches
// RQ8 - count starts first trigger, fires at value
// RQ9 - delay count must be positive
// RQ10 - shared arm arms every enabled unit
// RQ11 - shared disarm disarms every enabled unit
// RQ12 - disabled units ignore shared actions
// RQ13 - only one unit drives shared arming
// RQ14 - shared trace excludes shared actions
// RQ15 - break effect halts emulation
// RQ16 - too many comparators flags error
// RQ17 - after firing, idle until reload; the code also restarts on emul_start without a reload
package atbs_pkg;
	localparam int CNT_W = 16;
	localparam int CMP_W = 4;
	localparam logic [CMP_W-1:0] CMP_AVAIL = 4'h4;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

	typedef enum logic [1:0] {
		ATBS_DLY_NONE = 2'h0,
		ATBS_DLY_INSN = 2'h1,
		ATBS_DLY_OCC = 2'h2
	} atbs_dly_t;

	typedef enum logic [1:0] {
		ATBS_FX_BREAK = 2'h0,
		ATBS_FX_TRIG = 2'h1,
		ATBS_FX_ARM = 2'h2,
		ATBS_FX_DARM = 2'h3
	} atbs_fx_t;

	// gray path: idle -> arm search -> trigger search -> delay -> done
	typedef enum logic [2:0] {
		ATBS_ST_IDLE = 3'h0,
		ATBS_ST_ARMW = 3'h1,
		ATBS_ST_TRGW = 3'h3,
		ATBS_ST_DLY = 3'h2,
		ATBS_ST_DONE = 3'h6,
		ATBS_ST_ERR = 3'h7
	} atbs_st_t;
endpackage

// [include/atbs_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface atbs_link_if;
	logic arm_match;
	logic disarm_match;
	logic trig_match;
	logic insn_done;
	logic shared_trigger_line;
	logic shared_arm_action;
	logic shared_disarm_action;
	logic halt_emul;

	modport seq (
		input arm_match, disarm_match, trig_match, insn_done,
		output shared_trigger_line, shared_arm_action, shared_disarm_action, halt_emul
	);
	modport unit (
		output arm_match, disarm_match, trig_match, insn_done,
		input shared_trigger_line, shared_arm_action, shared_disarm_action, halt_emul
	);
endinterface
`default_nettype wire

// [verilog/atbs_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module atbs_sequencer
	import atbs_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// configuration from the probe software
	input wire logic emul_start,
	input wire logic cfg_load,
	input wire logic cfg_arm_en,
	input wire logic cfg_disarm_en,
	input wire atbs_dly_t cfg_dly_mode,
	input wire atbs_fx_t cfg_effect,
	input wire logic [CNT_W-1:0] cfg_count,
	input wire logic [CMP_W-1:0] cfg_cmp_need,
	input wire logic cfg_shared_trace,
	// status
	output logic cfg_error,
	output logic seq_armed,
	output logic seq_fired,
	// link
	atbs_link_if.seq link
);
	// state and counting
	atbs_st_t st_r;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_inc;
	logic cnt_hit;
	logic cnt_ev;
	// setup kept from the last restart
	logic dis_en_r;
	atbs_dly_t dly_r;
	atbs_fx_t fx_r;
	logic [CNT_W-1:0] count_r;
	// setup checks
	logic restart;
	logic bad_dis_alone;
	logic bad_dis_dly;
	logic bad_mode;
	logic bad_count;
	logic bad_trace;
	logic bad_cmp;
	logic bad_cfg;
	// effect side
	logic fire;
	logic err_r;
	logic fired_r;
	logic armed_r;
	logic halt_r;
	logic trg_r;
	logic sarm_r;
	logic sdarm_r;

	assign restart = emul_start || cfg_load;

	// a bad setup is refused as a whole rather than half run
	assign bad_dis_alone = cfg_disarm_en && !cfg_arm_en; // RQ4
	assign bad_dis_dly = cfg_disarm_en && cfg_dly_mode != ATBS_DLY_NONE; // RQ5
	// the spare mode code has no meaning, so it is refused as well
	assign bad_mode = cfg_dly_mode != ATBS_DLY_NONE && cfg_dly_mode != ATBS_DLY_INSN
		&& cfg_dly_mode != ATBS_DLY_OCC;
	assign bad_count = cfg_dly_mode != ATBS_DLY_NONE && cfg_count == CNT_RST; // RQ9
	assign bad_trace = cfg_shared_trace && cfg_effect != ATBS_FX_BREAK; // RQ14
	assign bad_cmp = cfg_cmp_need > CMP_AVAIL; // RQ16
	assign bad_cfg = bad_dis_alone || bad_dis_dly || bad_mode || bad_count || bad_trace || bad_cmp;

	// the run works from a copy taken at restart, so a late change of the
	// setup lines cannot bend a run that is already under way
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			dis_en_r <= 1'b0;
			dly_r <= ATBS_DLY_NONE;
			fx_r <= ATBS_FX_BREAK;
			count_r <= CNT_RST;
		end else if (restart) begin
			dis_en_r <= cfg_disarm_en;
			dly_r <= cfg_dly_mode;
			fx_r <= cfg_effect;
			count_r <= cfg_count;
		end
	end

	// count of events once the current one is taken in
	assign cnt_inc = CNT_W'(cnt_r + CNT_ONE);
	assign cnt_hit = cnt_inc == count_r;

	// the event that the delay counts in its mode
	always_comb begin
		cnt_ev = 1'b0;
		case (dly_r)
			ATBS_DLY_INSN: cnt_ev = link.insn_done; // RQ6
			ATBS_DLY_OCC: cnt_ev = link.trig_match; // RQ7
			default: cnt_ev = 1'b0;
		endcase
	end

	// fire decision for this cycle
	always_comb begin
		fire = 1'b0;
		case (st_r)
			ATBS_ST_TRGW: begin
				if (link.trig_match) begin
					fire = (dly_r == ATBS_DLY_NONE)
						|| (dly_r == ATBS_DLY_OCC && count_r == CNT_ONE); // RQ8
				end
			end
			ATBS_ST_DLY: begin
				fire = cnt_ev && cnt_hit; // RQ8
			end
			default: fire = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= ATBS_ST_IDLE;
		end else if (restart) begin
			if (bad_cfg)
				st_r <= ATBS_ST_ERR; // RQ16
			else if (cfg_arm_en)
				st_r <= ATBS_ST_ARMW; // RQ1
			else
				st_r <= ATBS_ST_TRGW; // RQ2
		end else begin
			case (st_r)
				ATBS_ST_ARMW: begin
					if (link.arm_match)
						st_r <= ATBS_ST_TRGW; // RQ1
				end
				ATBS_ST_TRGW: begin
					if (fire)
						st_r <= ATBS_ST_DONE; // RQ17
					else if (dis_en_r && link.disarm_match)
						st_r <= ATBS_ST_ARMW; // RQ3
					else if (link.trig_match && dly_r != ATBS_DLY_NONE)
						st_r <= ATBS_ST_DLY; // RQ8
				end
				ATBS_ST_DLY: begin
					if (fire)
						st_r <= ATBS_ST_DONE; // RQ17
				end
				// idle, done and error wait for the next restart
				ATBS_ST_IDLE: st_r <= ATBS_ST_IDLE;
				ATBS_ST_DONE: st_r <= ATBS_ST_DONE; // RQ17
				ATBS_ST_ERR: st_r <= ATBS_ST_ERR; // RQ16
				default: st_r <= ATBS_ST_IDLE;
			endcase
		end
	end

	// counter holds how many events are already counted
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= CNT_RST;
		end else if (restart) begin
			cnt_r <= CNT_RST;
		end else if (st_r == ATBS_ST_TRGW && link.trig_match) begin
			cnt_r <= (dly_r == ATBS_DLY_OCC) ? CNT_ONE : CNT_RST; // RQ8
		end else if (st_r == ATBS_ST_DLY && cnt_ev) begin
			cnt_r <= cnt_inc; // RQ6 RQ7
		end
	end

	// effect pulses, one cycle each
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			halt_r <= 1'b0;
			trg_r <= 1'b0;
			sarm_r <= 1'b0;
			sdarm_r <= 1'b0;
		end else begin
			halt_r <= fire && fx_r == ATBS_FX_BREAK; // RQ15
			trg_r <= fire && fx_r == ATBS_FX_TRIG;
			sarm_r <= fire && fx_r == ATBS_FX_ARM; // RQ10
			sdarm_r <= fire && fx_r == ATBS_FX_DARM; // RQ11
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			err_r <= 1'b0;
			fired_r <= 1'b0;
		end else if (restart) begin
			err_r <= bad_cfg;
			fired_r <= 1'b0;
		end else if (fire) begin
			fired_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			armed_r <= 1'b0;
		else
			armed_r <= (st_r == ATBS_ST_TRGW) || (st_r == ATBS_ST_DLY);
	end

	assign cfg_error = err_r;
	assign seq_fired = fired_r;
	assign seq_armed = armed_r;
	assign link.halt_emul = halt_r;
	assign link.shared_trigger_line = trg_r;
	assign link.shared_arm_action = sarm_r;
	assign link.shared_disarm_action = sdarm_r;
endmodule
`default_nettype wire

// [verilog/atbs_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module atbs_unit
	import atbs_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// local side
	input wire logic unit_enable,
	input wire logic arm_match_in,
	input wire logic disarm_match_in,
	input wire logic trig_match_in,
	input wire logic insn_done_in,
	output logic unit_armed,
	output logic unit_triggered,
	output logic unit_halted,
	// link
	atbs_link_if.unit link
);
	logic armed_r, trig_r, halt_r;
	logic am_r, dm_r, tm_r, id_r;

	// match events registered so the sequencer sees flop outputs
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			am_r <= 1'b0;
			dm_r <= 1'b0;
			tm_r <= 1'b0;
			id_r <= 1'b0;
		end else begin
			am_r <= arm_match_in;
			dm_r <= disarm_match_in;
			tm_r <= trig_match_in;
			id_r <= insn_done_in;
		end
	end

	// disarm wins if both shared actions arrive together
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			armed_r <= 1'b0;
		else if (!unit_enable)
			armed_r <= armed_r; // RQ12
		else if (link.shared_disarm_action)
			armed_r <= 1'b0; // RQ11
		else if (link.shared_arm_action)
			armed_r <= 1'b1; // RQ10
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			trig_r <= 1'b0;
			halt_r <= 1'b0;
		end else begin
			trig_r <= unit_enable && armed_r && link.shared_trigger_line; // RQ12
			halt_r <= link.halt_emul;
		end
	end

	assign link.arm_match = am_r;
	assign link.disarm_match = dm_r;
	assign link.trig_match = tm_r;
	assign link.insn_done = id_r;
	assign unit_armed = armed_r;
	assign unit_triggered = trig_r;
	assign unit_halted = halt_r;
endmodule
`default_nettype wire

// [sim/atbs_link_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module atbs_link_sva (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// link
	input wire logic trig_match,
	input wire logic insn_done,
	input wire logic shared_trigger_line,
	input wire logic shared_arm_action,
	input wire logic shared_disarm_action,
	input wire logic halt_emul
);
	wire logic [3:0] fx = {halt_emul, shared_trigger_line, shared_arm_action, shared_disarm_action};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// a reload plus a fresh match needs three edges, so two quiet cycles are safe
	halt_pulse_a: assert property (halt_emul |=> (fx == 4'h0)[*2]) else $error("halt repeated");
	trig_pulse_a: assert property (shared_trigger_line |=> (fx == 4'h0)[*2]) else $error("trig repeated");
	arm_pulse_a: assert property (shared_arm_action |=> (fx == 4'h0)[*2]) else $error("arm repeated");
	darm_pulse_a: assert property (shared_disarm_action |=> (fx == 4'h0)[*2]) else $error("darm repeated");
	one_effect_a: assert property ($onehot0(fx)) else $error("two effects at once");
	halt_cause_a: assert property (halt_emul |-> $past(trig_match) || $past(insn_done))
		else $error("halt without match");
	shared_cause_a: assert property (|fx[2:0] |-> $past(trig_match) || $past(insn_done))
		else $error("shared action without match");
	quiet_start_a: assert property ($rose(reset_n) |-> fx == 4'h0 ##1 fx == 4'h0)
		else $error("effect before load");
endmodule
`default_nettype wire

// [sim/arm_trigger_break_sequencer_test.sv]
`timescale 1ns/1ps
`default_nettype none
module arm_trigger_break_sequencer_test import atbs_pkg::*;;
	localparam logic Y = 1'h1;
	localparam logic N = 1'h0;
	logic clk_sys = 1'h0;
	logic reset_n = 1'h0;
	logic cfg_load = 1'h0;
	logic arm_en = 1'h0;
	logic darm_en = 1'h0;
	atbs_dly_t dly = ATBS_DLY_NONE;
	atbs_fx_t fx = ATBS_FX_BREAK;
	logic [CNT_W-1:0] cnt = CNT_ONE;
	logic [CMP_W-1:0] need = 4'h1;
	logic trace = 1'h0;
	logic enable = 1'h1;
	logic [3:0] pins = 4'h0;
	logic emul_start = 1'h0;
	logic cfg_error, seq_armed, seq_fired, unit_armed;
	logic unit_triggered, unit_halted;
	logic [7:0] trig_seen = 8'h00;
	logic [7:0] halt_seen = 8'h00;
	int fail_count = 0;
	int samples_checked = 0;
	atbs_link_if link ();
	always #5 clk_sys = ~clk_sys;
	// the unit's pulses are short, so they are tallied here and the tallies compared
	always @(posedge clk_sys) begin
		if (unit_triggered)
			trig_seen <= trig_seen + 8'h01;
		if (unit_halted)
			halt_seen <= halt_seen + 8'h01;
	end
	atbs_sequencer atbs_sequencer_inst (.clk_sys(clk_sys), .reset_n(reset_n),
		.emul_start(emul_start),
		.cfg_load(cfg_load), .cfg_arm_en(arm_en), .cfg_disarm_en(darm_en), .cfg_dly_mode(dly),
		.cfg_effect(fx), .cfg_count(cnt), .cfg_cmp_need(need), .cfg_shared_trace(trace),
		.cfg_error(cfg_error), .seq_armed(seq_armed), .seq_fired(seq_fired), .link(link));
	atbs_unit atbs_unit_inst (.clk_sys(clk_sys), .reset_n(reset_n), .unit_enable(enable),
		.arm_match_in(pins[0]), .disarm_match_in(pins[1]), .trig_match_in(pins[2]),
		.insn_done_in(pins[3]), .unit_armed(unit_armed), .unit_triggered(unit_triggered),
		.unit_halted(unit_halted),
		.link(link));
	atbs_link_sva atbs_link_sva_inst (.clk_sys(clk_sys), .reset_n(reset_n),
		.trig_match(link.trig_match), .insn_done(link.insn_done),
		.shared_trigger_line(link.shared_trigger_line), .shared_arm_action(link.shared_arm_action),
		.shared_disarm_action(link.shared_disarm_action), .halt_emul(link.halt_emul));
	task chk(input string nm, input logic e, g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %b seen %b", nm, e, g);
		end
	endtask
	task chk_n(input string nm, input logic [7:0] e, g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	// restart with the setup that is already loaded
	task go;
		emul_start <= Y;
		@(posedge clk_sys);
		emul_start <= N;
		repeat (2) @(posedge clk_sys);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task ld(input logic a, d, input atbs_dly_t m, input atbs_fx_t f, input logic [15:0] c,
		input logic [3:0] n, input logic t, e);
		arm_en <= a;
		darm_en <= d;
		dly <= m;
		fx <= f;
		cnt <= c;
		need <= n;
		trace <= t;
		cfg_load <= Y;
		@(posedge clk_sys);
		cfg_load <= N;
		repeat (2) @(posedge clk_sys);
		chk("cfg_error", e, cfg_error);
	endtask
	// one-cycle match pulse, then enough edges for the unit and sequencer registers
	task ev(input int i);
		pins[i] <= Y;
		@(posedge clk_sys);
		pins <= 4'h0;
		repeat (4) @(posedge clk_sys);
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		reset_n <= Y;
		@(posedge clk_sys);
		ld(Y, N, ATBS_DLY_NONE, ATBS_FX_BREAK, CNT_ONE, 4'h4, N, N);
		ev(2);
		chk("seq_fired", N, seq_fired);
		ev(0);
		chk("seq_armed", Y, seq_armed);
		ev(2);
		chk("seq_fired", Y, seq_fired);
		chk("seq_armed", N, seq_armed);
		chk_n("halt_seen", 8'h01, halt_seen);
		ld(Y, Y, ATBS_DLY_NONE, ATBS_FX_BREAK, CNT_ONE, 4'h1, N, N);
		ev(0);
		ev(1);
		chk("seq_armed", N, seq_armed);
		ev(2);
		chk("seq_fired", N, seq_fired);
		ev(0);
		ev(2);
		chk("seq_fired", Y, seq_fired);
		for (int i = 0; i < 4; i++) begin
			ld(N, N, ATBS_DLY_NONE, atbs_fx_t'(i), CNT_ONE, 4'h1, N, N);
			ev(2);
			chk("seq_fired", Y, seq_fired);
			chk("unit_armed", i == 2, unit_armed);
		end
		enable <= N;
		ld(N, N, ATBS_DLY_NONE, ATBS_FX_ARM, CNT_ONE, 4'h1, N, N);
		ev(2);
		chk("unit_armed", N, unit_armed);
		enable <= Y;
		ld(N, N, ATBS_DLY_NONE, ATBS_FX_ARM, CNT_ONE, 4'h1, N, N);
		ev(2);
		ld(N, N, ATBS_DLY_NONE, ATBS_FX_TRIG, CNT_ONE, 4'h1, N, N);
		ev(2);
		chk_n("trig_seen", 8'h01, trig_seen);
		enable <= N;
		ld(N, N, ATBS_DLY_NONE, ATBS_FX_TRIG, CNT_ONE, 4'h1, N, N);
		ev(2);
		chk_n("trig_seen", 8'h01, trig_seen);
		ld(N, N, ATBS_DLY_NONE, ATBS_FX_DARM, CNT_ONE, 4'h1, N, N);
		ev(2);
		chk("unit_armed", Y, unit_armed);
		enable <= Y;
		ld(N, N, ATBS_DLY_OCC, ATBS_FX_BREAK, 16'h0003, 4'h1, N, N);
		ev(2);
		ev(2);
		chk("seq_fired", N, seq_fired);
		ev(2);
		chk("seq_fired", Y, seq_fired);
		go;
		ev(2);
		ev(2);
		chk("seq_fired", N, seq_fired);
		ev(2);
		chk("seq_fired", Y, seq_fired);
		chk_n("halt_seen", 8'h05, halt_seen);
		ld(N, N, ATBS_DLY_INSN, ATBS_FX_BREAK, 16'h0002, 4'h1, N, N);
		ev(2);
		ev(3);
		chk("seq_fired", N, seq_fired);
		ev(3);
		chk("seq_fired", Y, seq_fired);
		ld(N, Y, ATBS_DLY_NONE, ATBS_FX_BREAK, CNT_ONE, 4'h1, N, Y);
		ld(Y, Y, ATBS_DLY_OCC, ATBS_FX_BREAK, 16'h0002, 4'h1, N, Y);
		ld(N, N, ATBS_DLY_OCC, ATBS_FX_BREAK, 16'h0000, 4'h1, N, Y);
		ld(N, N, ATBS_DLY_NONE, ATBS_FX_TRIG, CNT_ONE, 4'h1, Y, Y);
		ld(N, N, ATBS_DLY_NONE, ATBS_FX_BREAK, CNT_ONE, 4'h5, N, Y);
		ev(2);
		chk("seq_fired", N, seq_fired);
		// reset in mid-run clears the refused setup and the unit's arming
		reset_n <= N;
		repeat (2) @(posedge clk_sys);
		chk("cfg_error", N, cfg_error);
		chk("unit_armed", N, unit_armed);
		reset_n <= Y;
		@(posedge clk_sys);
		ld(N, N, ATBS_DLY_NONE, ATBS_FX_BREAK, CNT_ONE, 4'h1, Y, N);
		wrap_up;
	end
endmodule
`default_nettype wire
